//--- rtl/sbs_pkg.sv
package sbs_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int SBS_ADDR_W = 18;
    localparam int SBS_DATA_W = 18;
    localparam int SBS_SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int SBS_BURST_LSB = 0;
    localparam int SBS_BURST_W = 2;
    localparam logic [1:0] SBS_CNT_RST = 2'h0;
    localparam logic [1:0] SBS_CNT_STEP = 2'h1;
    localparam logic [SBS_SYNC_STAGES-1:0] SBS_SYNC_RST = 3'h0;
    localparam logic SBS_MODE_RST = 1'b1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SBS_IDLE = 2'b00,
        SBS_READ = 2'b01,
        SBS_WRITE = 2'b10,
        SBS_SLEEP = 2'b11
    } sbs_state_e;

    typedef struct packed {
        logic [SBS_ADDR_W-1:0] addr;
        logic cpu_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic select_enable_first_n;
        logic select_enable_second;
        logic select_enable_third_n;
        logic burst_advance_n;
        logic write_n;
    } sbs_ctrl_s;

endpackage : sbs_pkg

//--- rtl/sbs_burst_seq.sv
`timescale 1ns/1ps
`default_nettype none

module sbs_burst_seq
    import sbs_pkg::*;
(
    input wire logic interleave,
    input wire logic [1:0] start,
    input wire logic [1:0] count,
    output logic [1:0] word
);

    // Four-word wrap falls out of the two-bit width
    always_comb begin
        if (interleave) begin
            word = start ^ count; // (R19)
        end else begin
            word = 2'(start + count); // (R19)
        end
    end

endmodule // sbs_burst_seq

`default_nettype wire

//--- rtl/sbs_sram_core.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) All synchronous inputs are taken on the rising clock edge.
// (R2) Burst counter steps on an edge with advance sampled low.
// (R3) Processor strobe is ignored while first enable samples high.
// (R4) Chip enables matter only on edges that load a new address.
// (R5) First enable is active low, combined with the other two.
// (R6) Third enable is an active-low clocked depth-expansion select.
// (R7) Second enable is an active-high clocked select.
// (R8) Output enable is unclocked, active low; high floats the data lines.
// (R9) First read clock after deselect keeps data lines undriven.
// (R10) Advance during a burst makes the next burst address internally.
// (R11) Processor strobe low latches address, seeds counter with low bits.
// (R12) Controller strobe low also latches address and seeds counter.
// (R13) With both strobes low only the processor strobe acts.
// (R14) Sleep input high enters a quiet state keeping contents.
// (R15) Other party keeps sleep low or open in normal operation.
// (R16) Input data is captured on the rising edge when lines are inputs.
// (R17) Read data is the word addressed at the preceding edge.
// (R18) Order strap low gives linear bursts, high or open interleaved.
// (R19) Burst counter wraps in four words following the selected order.
// (R20) A load that does not select starts nothing, lines stay undriven.
module sbs_sram_core
    import sbs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire sbs_ctrl_s ctrl,
    input wire logic [SBS_DATA_W-1:0] dq_in,
    output logic [SBS_DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    output logic sleep_active
);

    localparam int DEPTH = 1 << SBS_ADDR_W;
    localparam int HI_W = SBS_ADDR_W - SBS_BURST_W;

    // ----------------------------------------------------------------
    // Pin synchronisers for sleep and the order strap
    // ----------------------------------------------------------------
    logic [SBS_SYNC_STAGES-1:0] sleep_sync;
    logic [SBS_SYNC_STAGES-1:0] strap_sync;
    logic [SBS_SYNC_STAGES-1:0] next_sleep_sync;
    logic [SBS_SYNC_STAGES-1:0] next_strap_sync;
    logic sleep_level;
    logic next_sleep_level;
    logic interleave;
    logic next_interleave;
    logic strap_taken;
    logic next_strap_taken;
    // Marks which synchroniser stages already hold pin samples
    logic [SBS_SYNC_STAGES-1:0] strap_fill;
    logic [SBS_SYNC_STAGES-1:0] next_strap_fill;

    always_comb begin
        next_sleep_sync = {sleep_sync[1:0], sleep_request};
        next_strap_sync = {strap_sync[1:0], burst_order_strap};
        next_sleep_level = sleep_level;
        next_interleave = interleave;
        next_strap_taken = strap_taken;
        next_strap_fill = {strap_fill[1:0], 1'b1};
        if (sleep_sync[1] == sleep_sync[2]) begin
            next_sleep_level = sleep_sync[2]; // (R14)
        end
        // Strap is static, so it is caught once after reset and held.
        // Reset zeros in the chain are no pin samples: wait until full,
        // else a strap tied high would read as linear on the first edge
        if (!strap_taken && strap_fill[SBS_SYNC_STAGES-1]
            && strap_sync[1] == strap_sync[2]) begin
            next_interleave = strap_sync[2]; // (R18)
            next_strap_taken = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_sync <= SBS_SYNC_RST;
            strap_sync <= SBS_SYNC_RST;
            sleep_level <= 1'b0;
            interleave <= SBS_MODE_RST;
            strap_taken <= 1'b0;
            strap_fill <= SBS_SYNC_RST;
        end else begin
            sleep_sync <= next_sleep_sync;
            strap_sync <= next_strap_sync;
            sleep_level <= next_sleep_level;
            interleave <= next_interleave;
            strap_taken <= next_strap_taken;
            strap_fill <= next_strap_fill;
        end
    end

    // ----------------------------------------------------------------
    // Address capture and burst control
    // ----------------------------------------------------------------
    sbs_state_e state;
    sbs_state_e next_state;
    logic [HI_W-1:0] addr_hi;
    logic [HI_W-1:0] next_addr_hi;
    logic [1:0] burst_start;
    logic [1:0] next_burst_start;
    logic [1:0] burst_cnt;
    logic [1:0] next_burst_cnt;
    logic first_mask;
    logic next_first_mask;
    logic load_cpu;
    logic load_ctrl;
    logic selected;
    logic [1:0] next_word;
    logic [SBS_ADDR_W-1:0] next_addr;

    always_comb begin
        // Processor strobe blocked by first enable; controller yields
        load_cpu = !ctrl.cpu_addr_strobe_n
            && !ctrl.select_enable_first_n; // (R3) (R11)
        load_ctrl = !ctrl.ctrl_addr_strobe_n
            && ctrl.cpu_addr_strobe_n; // (R12) (R13)
        selected = !ctrl.select_enable_first_n // (R5)
            && ctrl.select_enable_second // (R7)
            && !ctrl.select_enable_third_n; // (R6)
        next_state = state;
        next_addr_hi = addr_hi;
        next_burst_start = burst_start;
        next_burst_cnt = burst_cnt;
        next_first_mask = 1'b0;
        if (sleep_level) begin
            next_state = SBS_SLEEP; // (R14)
        end else if (load_cpu || load_ctrl) begin
            // Enables looked at only here, never mid-burst
            if (selected) begin // (R4)
                next_addr_hi = ctrl.addr[SBS_ADDR_W-1:SBS_BURST_W]; // (R1)
                next_burst_start = ctrl.addr[1:0]; // (R11) (R12)
                next_burst_cnt = SBS_CNT_RST;
                next_state = ctrl.write_n ? SBS_READ : SBS_WRITE;
                next_first_mask = ctrl.write_n
                    && (state == SBS_IDLE || state == SBS_SLEEP); // (R9)
            end else begin
                next_state = SBS_IDLE; // (R20)
            end
        end else begin
            case (state)
                SBS_READ, SBS_WRITE: begin
                    if (!ctrl.burst_advance_n) begin
                        next_burst_cnt = 2'(burst_cnt + SBS_CNT_STEP); // (R2) (R10)
                    end
                    next_state = ctrl.write_n ? SBS_READ : SBS_WRITE;
                end
                SBS_SLEEP: begin
                    next_state = SBS_IDLE;
                end
                default: begin
                    next_state = SBS_IDLE;
                end
            endcase
        end
    end

    // Kept out of the process above: next_word derives from its outputs
    assign next_addr = {next_addr_hi, next_word};

    sbs_burst_seq u_burst_seq (
        .interleave(interleave),
        .start(next_burst_start),
        .count(next_burst_cnt),
        .word(next_word)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= SBS_IDLE;
            addr_hi <= '0;
            burst_start <= SBS_CNT_RST;
            burst_cnt <= SBS_CNT_RST;
            first_mask <= 1'b0;
        end else begin
            state <= next_state;
            addr_hi <= next_addr_hi;
            burst_start <= next_burst_start;
            burst_cnt <= next_burst_cnt;
            first_mask <= next_first_mask;
        end
    end

    // ----------------------------------------------------------------
    // Storage array and data path
    // ----------------------------------------------------------------
    logic [SBS_DATA_W-1:0] mem [DEPTH];
    logic [SBS_DATA_W-1:0] rd_data;

    // Array carries no reset; contents survive sleep untouched
    always_ff @(posedge clk) begin
        if (next_state == SBS_WRITE) begin
            mem[next_addr] <= dq_in; // (R16)
        end
    end

    // Flow-through: word for the edge's address is ready right after it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (next_state == SBS_READ) begin
            rd_data <= mem[next_addr]; // (R17)
        end
    end

    // Enable is unclocked so the far side can turn the bus at once;
    // raw sleep pin also floats the lines before the synchroniser sees it
    always_comb begin
        dq_out = rd_data;
        dq_oe = !output_enable_n // (R8)
            && !sleep_request // (R14)
            && state == SBS_READ // (R20)
            && !first_mask; // (R9)
        sleep_active = state == SBS_SLEEP;
    end

endmodule // sbs_sram_core

`default_nettype wire

//--- verif/sbs_sram_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_core_chk
    import sbs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire sbs_ctrl_s ctrl,
    input wire logic [SBS_DATA_W-1:0] dq_in,
    input wire logic [SBS_DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    input wire logic sleep_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic ld, sel, rd;
    // Blocked cpu strobe also blocks the ctrl strobe
    assign ld = (!ctrl.cpu_addr_strobe_n && !ctrl.select_enable_first_n)
        || (!ctrl.ctrl_addr_strobe_n && ctrl.cpu_addr_strobe_n);
    assign sel = !ctrl.select_enable_first_n && ctrl.select_enable_second
        && !ctrl.select_enable_third_n;
    assign rd = !output_enable_n && !sleep_request && !sleep_active;
    oe_float_a: assert property (output_enable_n |-> !dq_oe)
        else $error("data lines driven with output enable high");
    sleep_float_a: assert property (sleep_request |-> !dq_oe)
        else $error("data lines driven in sleep");
    sleep_enter_a: assert property (sleep_request[*6] |-> sleep_active)
        else $error("sleep not entered");
    sleep_leave_a: assert property (!sleep_request[*6] |-> !sleep_active)
        else $error("sleep not left");
    desel_float_a: assert property (ld && !sel |=> !dq_oe)
        else $error("unselected load drives data lines");
    first_mask_a: assert property ((ld && !sel) ##1
        (ld && sel && ctrl.write_n && rd) |=> !dq_oe)
        else $error("first read clock not masked");
    mask_clear_a: assert property ((ld && !sel) ##1 (ld && sel &&
        ctrl.write_n && rd) ##1 (!ld && ctrl.write_n && rd) |=>
        (dq_oe || output_enable_n || sleep_request))
        else $error("burst read not driven");
    cpu_block_a: assert property (dq_oe && rd && ctrl.write_n &&
        !ctrl.cpu_addr_strobe_n && ctrl.select_enable_first_n |=>
        (dq_oe || output_enable_n || sleep_request))
        else $error("blocked strobe acted");
endmodule // sbs_sram_core_chk
bind sbs_sram_core sbs_sram_core_chk u_sbs_sram_core_chk (.clk(clk),
    .rstn(rstn), .ctrl(ctrl), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .burst_order_strap(burst_order_strap),
    .sleep_active(sleep_active));
`default_nettype wire

//--- verif/sbs_bus_host.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_host
    import sbs_pkg::*;
(
    input wire logic clk,
    input wire logic [SBS_DATA_W-1:0] host_data,
    input wire logic host_drive,
    input wire logic [SBS_DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic sleep_cmd,
    output logic [SBS_DATA_W-1:0] dq_in,
    output logic sleep_request
);
    logic [SBS_DATA_W-1:0] last = '0;
    always_ff @(posedge clk) begin
        last <= dq_in;
    end
    // Released lines toggle so stale data never looks valid
    assign dq_in = dq_oe ? dq_out : (host_drive ? host_data : ~last);
    assign sleep_request = sleep_cmd;
endmodule // sbs_bus_host
`default_nettype wire

//--- verif/sbs_sram_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_core_tb
    import sbs_pkg::*;
;
    logic clk, rstn, oe_n, slp, strap, hoe, dq_oe, sreq, sact;
    logic [17:0] hd, dq_in, dq_out;
    sbs_ctrl_s ctrl;
    int num_errors = 0;
    int total_checks = 0;
    // Rows: ctrl, write data, read data, data line enable
    logic [61:0] rows [13] = '{
        {18'h00101, 7'h2A, 18'h11111, 18'h0, 1'b0},
        {18'h0, 7'h70, 18'h22222, 18'h0, 1'b0},
        {18'h0, 7'h70, 18'h33333, 18'h0, 1'b0},
        {18'h0, 7'h70, 18'h44444, 18'h0, 1'b0},
        {18'h0, 7'h43, 18'h0, 18'h0, 1'b0},
        {18'h00102, 7'h4B, 18'h0, 18'h44444, 1'b0},
        {18'h0, 7'h69, 18'h0, 18'h33333, 1'b1},
        {18'h0, 7'h6B, 18'h0, 18'h33333, 1'b1},
        {18'h0, 7'h69, 18'h0, 18'h22222, 1'b1},
        {18'h0, 7'h69, 18'h0, 18'h11111, 1'b1},
        {18'h0, 7'h69, 18'h0, 18'h44444, 1'b1},
        {18'h00101, 7'h1B, 18'h0, 18'h44444, 1'b1},
        {18'h00100, 7'h2B, 18'h0, 18'h22222, 1'b1}};
    sbs_sram_core u_sbs_sram_core (.clk(clk), .rstn(rstn), .ctrl(ctrl),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .output_enable_n(oe_n), .sleep_request(sreq),
        .burst_order_strap(strap), .sleep_active(sact));
    sbs_bus_host u_sbs_bus_host (.clk(clk), .host_data(hd),
        .host_drive(hoe), .dq_out(dq_out), .dq_oe(dq_oe),
        .sleep_cmd(slp), .dq_in(dq_in), .sleep_request(sreq));
    task automatic chk(input string n, input logic [17:0] s, e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic step(input logic [24:0] c, input logic [17:0] d, q,
        input logic oe);
        ctrl = sbs_ctrl_s'(c);
        hd = d;
        hoe = !c[0];
        @(negedge clk);
        chk("dq_out", dq_out, q);
        chk("dq_oe", {17'h0, dq_oe}, {17'h0, oe});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #100us;
        num_errors++;
        results();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        ctrl = sbs_ctrl_s'({18'h0, 7'h7F});
        {oe_n, slp, hoe, strap, hd} = {3'h0, 1'b1, 18'h0};
        repeat (6) @(negedge clk);
        chk("rst dq_oe", {17'h0, dq_oe}, 18'h0);
        chk("rst dq_out", dq_out, 18'h0);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 13; i++) begin
            step(rows[i][61:37], rows[i][36:19], rows[i][18:1], rows[i][0]);
        end
        ctrl = sbs_ctrl_s'({18'h0, 7'h7F});
        slp = 1'b1;
        strap = 1'b0;
        repeat (6) @(negedge clk);
        chk("sleep", {17'h0, sact}, 18'h1);
        chk("sleep dq_oe", {17'h0, dq_oe}, 18'h0);
        slp = 1'b0;
        repeat (6) @(negedge clk);
        chk("wake", {17'h0, sact}, 18'h0);
        // Strap is taken once after reset, so a new order needs a reset
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        chk("rst2 dq_out", dq_out, 18'h0);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk("rst2 dq_oe", {17'h0, dq_oe}, 18'h0);
        // Linear order from low bits 01
        step({18'h00101, 7'h2B}, 18'h0, 18'h11111, 1'b0);
        step({18'h0, 7'h69}, 18'h0, 18'h44444, 1'b1);
        step({18'h0, 7'h69}, 18'h0, 18'h33333, 1'b1);
        step({18'h0, 7'h69}, 18'h0, 18'h22222, 1'b1);
        oe_n = 1'b1;
        #1;
        chk("oe high", {17'h0, dq_oe}, 18'h0);
        @(negedge clk);
        oe_n = 1'b0;
        #1;
        chk("oe low", {17'h0, dq_oe}, 18'h1);
        chk("wrap", dq_out, 18'h11111);
        results();
    end
endmodule // sbs_sram_core_tb
`default_nettype wire
